// >>> hw/timer_counter.sv
// timer/counter with prescaler, external count pin and AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
module timer_counter (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  // read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // external count pin and interrupt
  input wire logic ext_count_pin,
  output logic irq
);
  import timer_pkg::*;

  typedef struct packed {
    logic [7:0] timer_control;
    logic [15:0] count;
    logic [7:0] prescale_cnt;
    logic [1:0] instr_div;
    logic overflow_flag;
    logic overflow_mask;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
  } timer_state_t;

  timer_state_t st_reg, st_next;
  logic ext_edge;

  function automatic logic [7:0] ratio_mask(input logic [2:0] code);
    // terminal count of the prescaler: ratio 2^(code+1) minus one
    ratio_mask = 8'((9'h002 << code) - 9'h001);
  endfunction : ratio_mask

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
      input logic [3:0] strb);
    merge_byte = strb[0] ? d[7:0] : old;
  endfunction : merge_byte

  edge_sync u_edge_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(ext_count_pin),
    .falling(st_reg.timer_control[BIT_EDGE]),
    .edge_pulse(ext_edge)
  );

  logic src_tick;
  logic count_tick;
  logic wrap;
  logic do_write;
  logic do_read;
  logic [15:0] count_inc;

  always_comb begin
    st_next = st_reg;
    src_tick = 1'b0;
    count_tick = 1'b0;
    wrap = 1'b0;
    count_inc = 16'h0000;
    do_write = 1'b0;
    do_read = 1'b0;

    // instruction-cycle clock enable
    st_next.instr_div = st_reg.instr_div + 2'd1;
    if (st_reg.timer_control[BIT_SRC]) begin
      src_tick = ext_edge;
    end else begin
      src_tick = (st_reg.instr_div == 2'(INSTR_DIV - 1));
    end

    // prescaler or bypass
    if (st_reg.timer_control[BIT_RUN] && src_tick) begin
      if (st_reg.timer_control[BIT_BYPASS]) begin
        count_tick = 1'b1;
      end else begin
        if ((st_reg.prescale_cnt & ratio_mask(st_reg.timer_control[BIT_PS_HI:0]))
            == ratio_mask(st_reg.timer_control[BIT_PS_HI:0])) begin
          count_tick = 1'b1;
          st_next.prescale_cnt = 8'h00;
        end else begin
          st_next.prescale_cnt = st_reg.prescale_cnt + 8'h01;
        end
      end
    end

    // counter and wrap
    if (count_tick) begin
      count_inc = st_reg.count + 16'h0001;
      if (st_reg.timer_control[BIT_NARROW]) begin
        st_next.count = {st_reg.count[15:8], count_inc[7:0]};
        wrap = (st_reg.count[7:0] == 8'hFF);
      end else begin
        st_next.count = count_inc;
        wrap = (st_reg.count == 16'hFFFF);
      end
    end

    // write channel: address and data in either order
    if (awvalid && !st_reg.aw_held) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = awaddr;
    end
    if (wvalid && !st_reg.w_held) begin
      st_next.w_held = 1'b1;
      st_next.w_data = wdata;
      st_next.w_strb = wstrb;
    end
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
      do_write = 1'b1;
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      if (st_reg.aw_addr == ADDR_CONTROL) begin
        st_next.timer_control = merge_byte(st_reg.timer_control, st_reg.w_data,
            st_reg.w_strb);
      end else if (st_reg.aw_addr == ADDR_COUNT) begin
        if (st_reg.w_strb[0]) begin
          st_next.count[7:0] = st_reg.w_data[7:0];
        end
        if (st_reg.w_strb[1]) begin
          st_next.count[15:8] = st_reg.w_data[15:8];
        end
        st_next.prescale_cnt = 8'h00;
      end else if (st_reg.aw_addr == ADDR_STATUS) begin
        st_next.bresp = RESP_OKAY;
      end else if (st_reg.aw_addr == ADDR_MASK) begin
        if (st_reg.w_strb[0]) begin
          st_next.overflow_mask = st_reg.w_data[BIT_OVF];
        end
      end else begin
        st_next.bresp = RESP_SLVERR;
      end
    end
    if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
    end

    // read channel
    if (arvalid && !st_reg.rvalid) begin
      do_read = 1'b1;
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      st_next.rdata = 32'h00000000;
      if (araddr == ADDR_CONTROL) begin
        st_next.rdata = {24'h000000, st_reg.timer_control};
      end else if (araddr == ADDR_COUNT) begin
        st_next.rdata = {16'h0000, st_reg.count};
      end else if (araddr == ADDR_STATUS) begin
        st_next.rdata = {31'h00000000, st_reg.overflow_flag};
        st_next.overflow_flag = 1'b0;
      end else if (araddr == ADDR_MASK) begin
        st_next.rdata = {31'h00000000, st_reg.overflow_mask};
      end else begin
        st_next.rresp = RESP_SLVERR;
      end
    end
    if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
    end

    // sticky flag: a new overflow wins over the read clear
    if (wrap) begin
      st_next.overflow_flag = 1'b1;
    end
    st_next.irq = st_next.overflow_flag & st_next.overflow_mask;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.timer_control <= CONTROL_RESET;
      st_reg.count <= COUNT_RESET;
      st_reg.overflow_mask <= MASK_RESET[0];
    end else begin
      st_reg <= st_next;
    end
  end

  assign awready = !st_reg.aw_held;
  assign wready = !st_reg.w_held;
  assign bvalid = st_reg.bvalid;
  assign bresp = st_reg.bresp;
  assign arready = !st_reg.rvalid;
  assign rvalid = st_reg.rvalid;
  assign rdata = st_reg.rdata;
  assign rresp = st_reg.rresp;
  assign irq = st_reg.irq;

  // the instruction-cycle divider is two bits wide
  if (INSTR_DIV != 4) begin : g_div_check
    $error("instruction divider must be four");
  end

  // checks
  a_wrap_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      wrap |=> st_reg.overflow_flag)
    else $error("overflow flag not set after wrap");
  a_narrow_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
      (count_tick && st_reg.timer_control[BIT_NARROW] && st_reg.count[7:0] == 8'hFF
      && !do_write) |=> st_reg.count[7:0] == 8'h00)
    else $error("8-bit wrap did not reach zero");
  a_wide_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
      (count_tick && !st_reg.timer_control[BIT_NARROW] && !do_write)
      |=> st_reg.count == $past(st_reg.count) + 16'h0001)
    else $error("16-bit count did not advance");
  a_halt_holds: assert property (@(posedge aclk) disable iff (!aresetn)
      !st_reg.timer_control[BIT_RUN] |-> !count_tick)
    else $error("counter ticked while halted");
  a_bypass_direct: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_reg.timer_control[BIT_RUN] && st_reg.timer_control[BIT_BYPASS] && src_tick)
      |-> count_tick)
    else $error("bypass did not pass source tick");
  a_internal_rate: assert property (@(posedge aclk) disable iff (!aresetn)
      (!st_reg.timer_control[BIT_SRC] && src_tick) |=> !src_tick [*3])
    else $error("internal tick faster than instruction cycle");
  a_prescale_gap: assert property (@(posedge aclk) disable iff (!aresetn)
      (count_tick && !st_reg.timer_control[BIT_BYPASS]) |-> st_reg.prescale_cnt
      == ratio_mask(st_reg.timer_control[BIT_PS_HI:0]))
    else $error("prescaler fired at wrong count");
  a_ext_source: assert property (@(posedge aclk) disable iff (!aresetn)
      st_reg.timer_control[BIT_SRC] |-> (src_tick == ext_edge))
    else $error("external source not followed");
  a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      wrap && st_reg.overflow_mask |=> irq)
    else $error("interrupt not raised on overflow");
  a_ctrl_readback: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_read && araddr == ADDR_CONTROL)
      |=> rdata[7:0] == $past(st_reg.timer_control))
    else $error("control readback mismatch");
  a_reset_ones: assert property (@(posedge aclk)
      $rose(aresetn) |-> st_reg.timer_control == CONTROL_RESET)
    else $error("control not all ones after reset");

  // register bus and flag behaviour
  a_status_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_read && araddr == ADDR_STATUS && !wrap) |=> !st_reg.overflow_flag)
    else $error("status read did not clear the flag");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
      irq == (st_reg.overflow_flag && st_reg.overflow_mask))
    else $error("interrupt does not follow flag and mask");
  a_ctrl_write: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && st_reg.aw_addr == ADDR_CONTROL && st_reg.w_strb[0])
      |=> st_reg.timer_control == $past(st_reg.w_data[7:0]))
    else $error("control write did not land");
  a_bad_read_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_read && araddr != ADDR_CONTROL && araddr != ADDR_COUNT
      && araddr != ADDR_STATUS && araddr != ADDR_MASK) |=> rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  a_bad_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && st_reg.aw_addr != ADDR_CONTROL && st_reg.aw_addr != ADDR_COUNT
      && st_reg.aw_addr != ADDR_STATUS && st_reg.aw_addr != ADDR_MASK)
      |=> bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  a_bvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
      (bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("write response dropped before bready");
  a_rvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
      (rvalid && !rready) |=> rvalid && $stable(rdata))
    else $error("read data dropped before rready");

  // counting path
  a_narrow_upper: assert property (@(posedge aclk) disable iff (!aresetn)
      (count_tick && st_reg.timer_control[BIT_NARROW] && !do_write)
      |=> st_reg.count[15:8] == $past(st_reg.count[15:8]))
    else $error("8-bit mode disturbed the upper byte");
  a_wide_carry: assert property (@(posedge aclk) disable iff (!aresetn)
      (count_tick && !st_reg.timer_control[BIT_NARROW] && st_reg.count == 16'hFFFF
      && !do_write) |=> st_reg.count == 16'h0000)
    else $error("16-bit wrap did not reach zero");
  a_wrap_on_tick: assert property (@(posedge aclk) disable iff (!aresetn)
      wrap |-> count_tick)
    else $error("overflow without a count tick");
  a_edge_single: assert property (@(posedge aclk) disable iff (!aresetn)
      ext_edge |=> !ext_edge)
    else $error("pin edge pulse longer than one cycle");
  a_prescale_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && st_reg.aw_addr == ADDR_COUNT) |=> st_reg.prescale_cnt == 8'h00)
    else $error("count write did not restart the prescaler");
  a_tick_needs_src: assert property (@(posedge aclk) disable iff (!aresetn)
      !src_tick |-> !count_tick)
    else $error("count tick without a source tick");
  a_halt_prescale: assert property (@(posedge aclk) disable iff (!aresetn)
      (!st_reg.timer_control[BIT_RUN] && !do_write)
      |=> st_reg.prescale_cnt == $past(st_reg.prescale_cnt))
    else $error("prescaler moved while halted");

  c_overflow: cover property (@(posedge aclk) disable iff (!aresetn) wrap);
  c_ext_count: cover property (@(posedge aclk) disable iff (!aresetn)
      count_tick && st_reg.timer_control[BIT_SRC]);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  c_wide_mode: cover property (@(posedge aclk) disable iff (!aresetn)
      wrap && !st_reg.timer_control[BIT_NARROW]);
  c_slow_ratio: cover property (@(posedge aclk) disable iff (!aresetn)
      count_tick && !st_reg.timer_control[BIT_BYPASS] && st_reg.timer_control[2:0] == 3'h7);
endmodule : timer_counter
`default_nettype wire

// >>> hw/timer_pkg.sv
// package: register map, field positions, reset values and timing for the timer/counter
package timer_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  localparam int BIT_RUN = 7;
  localparam int BIT_NARROW = 6;
  localparam int BIT_SRC = 5;
  localparam int BIT_EDGE = 4;
  localparam int BIT_BYPASS = 3;
  localparam int BIT_PS_HI = 2;
  localparam int BIT_OVF = 0;
  localparam logic [7:0] CONTROL_RESET = 8'hFF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // instruction cycle is four system clocks
  localparam int INSTR_DIV = 4;
endpackage : timer_pkg

// >>> hw/edge_sync.sv
// pin synchroniser with selectable edge detection
`timescale 1ns/100ps
`default_nettype none
module edge_sync (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pin and edge choice
  input wire logic pin,
  input wire logic falling,
  // one-cycle pulse on the chosen edge
  output logic edge_pulse
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pulse;
  } sync_state_t;
  sync_state_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (falling) begin
      st_next.pulse = st_reg.s3 & ~st_reg.s2;
    end else begin
      st_next.pulse = ~st_reg.s3 & st_reg.s2;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign edge_pulse = st_reg.pulse;
endmodule : edge_sync
`default_nettype wire

// >>> bench/count_source.sv
// external pulse source that drives the timer's count pin
`timescale 1ns/100ps
`default_nettype none
module count_source (
  // clock
  input wire logic aclk,
  // pin towards the timer
  output logic pin
);
  initial pin = 1'b0;
  // hold each level long enough for synchroniser and edge detector to land
  task automatic set_level(input logic lvl);
    @(posedge aclk);
    pin <= lvl;
    repeat (8) @(posedge aclk);
  endtask : set_level
  task automatic pulse(input int n);
    repeat (n) begin
      set_level(1'b1);
      set_level(1'b0);
    end
  endtask : pulse
endmodule : count_source
`default_nettype wire

// >>> bench/tb_top.sv
// testbench: register bus tasks and timer scenarios
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import timer_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, pin;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp, rs;
  int n_mismatch = 0, num_checks = 0, m;
  timer_counter DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .ext_count_pin(pin), .irq);
  count_source src (.aclk, .pin);
  initial forever #12.5 aclk = ~aclk;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic fail(input string s);
    n_mismatch++;
    $display("unexpected at %0t: %s", $time, s);
  endtask : fail
  task automatic timeout();
    fail("wait ran out");
    print_verdict();
  endtask : timeout
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) fail($sformatf("got %h expected %h", g, e));
  endtask : chk
  task automatic chk_rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    num_checks++;
    if ((g >= lo && g <= hi) !== 1'b1) fail($sformatf("got %h outside %h..%h", g, lo, hi));
  endtask : chk_rng
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    int i;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (i == 50) timeout();
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr
  task automatic rdt(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (i == 50) timeout();
  endtask : rdt
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    rdt(a, rd, rs);
    chk(rd, e);
    chk({30'h0, rs}, {30'h0, er});
  endtask : rc
  task automatic wait_irq(input logic lvl);
    int i;
    for (i = 0; i < 100 && irq !== lvl; i++) @(posedge aclk);
    if (i == 100) timeout();
    num_checks++;
  endtask : wait_irq
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rc(ADDR_CONTROL, 32'hFF);
    rc(ADDR_COUNT, 32'h0);
    rc(ADDR_MASK, 32'h0);
    rc(ADDR_STATUS, 32'h0);
    wr(ADDR_CONTROL, 32'h5A);
    rc(ADDR_CONTROL, 32'h5A);
    wr(8'h10, 32'h1, RESP_SLVERR);
    rc(8'h10, 32'h0, RESP_SLVERR);
    // from FEh: narrow mode wraps, wide mode carries on; halted count holds
    for (m = 0; m < 2; m++) begin
      wr(ADDR_CONTROL, m ? 32'h48 : 32'h08);
      wr(ADDR_COUNT, 32'hFE);
      wr(ADDR_CONTROL, m ? 32'hC8 : 32'h88);
      repeat (40) @(posedge aclk);
      wr(ADDR_CONTROL, m ? 32'h48 : 32'h08);
      rdt(ADDR_COUNT, rd, rs);
      chk_rng(rd, m ? 32'h1 : 32'h101, m ? 32'h10 : 32'h110);
      repeat (50) @(posedge aclk);
      rc(ADDR_COUNT, rd);
      rc(ADDR_STATUS, m);
      chk({31'h0, irq}, 32'h0);
    end
    wr(ADDR_COUNT, 32'hFFFE);
    wr(ADDR_MASK, 32'h1);
    wr(ADDR_CONTROL, 32'h88);
    wait_irq(1'b1);
    wr(ADDR_CONTROL, 32'h08);
    rc(ADDR_STATUS, 32'h1);
    wait_irq(1'b0);
    rc(ADDR_STATUS, 32'h0);
    // every ratio code: run for four prescaled counts
    for (m = 0; m < 8; m++) begin
      wr(ADDR_CONTROL, m);
      wr(ADDR_COUNT, 32'h0);
      wr(ADDR_CONTROL, 32'h80 | m);
      repeat (32 << m) @(posedge aclk);
      wr(ADDR_CONTROL, m);
      rdt(ADDR_COUNT, rd, rs);
      chk_rng(rd, 32'h3, 32'h5);
    end
    // pin counting, rising then falling edge
    for (m = 0; m < 2; m++) begin
      wr(ADDR_CONTROL, m ? 32'h38 : 32'h28);
      wr(ADDR_COUNT, 32'h0);
      wr(ADDR_CONTROL, m ? 32'hB8 : 32'hA8);
      src.set_level(1'b1);
      rc(ADDR_COUNT, m ? 32'h0 : 32'h1);
      src.set_level(1'b0);
      rc(ADDR_COUNT, 32'h1);
      src.pulse(4);
      rc(ADDR_COUNT, 32'h5);
    end
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
